// ==== verilog/bfx_pkg.sv ====
// constants, types and field layouts of the branch/bit/flag execution unit
package bfx_pkg;

	// status flag positions
	localparam logic [2:0] BFX_FLAG_C = 3'h0;
	localparam logic [2:0] BFX_FLAG_Z = 3'h1;
	localparam logic [2:0] BFX_FLAG_N = 3'h2;
	localparam logic [2:0] BFX_FLAG_V = 3'h3;
	localparam logic [2:0] BFX_FLAG_S = 3'h4;
	localparam logic [2:0] BFX_FLAG_H = 3'h5;
	localparam logic [2:0] BFX_FLAG_T = 3'h6;
	localparam logic [2:0] BFX_FLAG_I = 3'h7;

	localparam logic [7:0]  BFX_STATUS_FLAGS_REGISTER_RST = 8'h00;
	localparam logic [15:0] BFX_PC_RST   = 16'h0000;
	localparam logic [7:0]  BFX_BYTE_RST = 8'h00;

	// pc steps
	localparam logic [15:0] BFX_PC_STEP      = 16'h0001;
	localparam logic [15:0] BFX_PC_SKIP_ONE  = 16'h0002;
	localparam logic [15:0] BFX_PC_SKIP_TWO  = 16'h0003;

	// cycle counts
	localparam logic [1:0] BFX_CYC_ONE   = 2'h1;
	localparam logic [1:0] BFX_CYC_TWO   = 2'h2;
	localparam logic [1:0] BFX_CYC_THREE = 2'h3;

	// register bus map
	localparam logic [4:0] BFX_ADDR_STATUS = 5'h00;
	localparam logic [4:0] BFX_ADDR_PC_LO  = 5'h01;
	localparam logic [4:0] BFX_ADDR_PC_HI  = 5'h02;
	localparam logic [1:0] BFX_REGION_GPR  = 2'h1;
	localparam logic [1:0] BFX_REGION_IO   = 2'h2;

	typedef enum logic [5:0] {
		BFX_OP_NOP                   = 6'h00,
		BFX_OP_SKIP_IF_IO_BIT_ONE    = 6'h01,
		BFX_OP_SKIP_IF_IO_BIT_ZERO   = 6'h02,
		BFX_OP_BRANCH_FLAG_S_SET     = 6'h03,
		BFX_OP_BRANCH_FLAG_S_CLEAR   = 6'h04,
		BFX_OP_BRANCH_EQUAL          = 6'h05,
		BFX_OP_BRANCH_NOT_EQUAL      = 6'h06,
		BFX_OP_BRANCH_CARRY_ONE      = 6'h07,
		BFX_OP_BRANCH_CARRY_ZERO     = 6'h08,
		BFX_OP_BRANCH_UNSIGNED_GE    = 6'h09,
		BFX_OP_BRANCH_UNSIGNED_LT    = 6'h0a,
		BFX_OP_BRANCH_NEGATIVE       = 6'h0b,
		BFX_OP_BRANCH_POSITIVE       = 6'h0c,
		BFX_OP_BRANCH_SIGNED_GE      = 6'h0d,
		BFX_OP_BRANCH_SIGNED_LT      = 6'h0e,
		BFX_OP_BRANCH_HALF_CARRY_ONE = 6'h0f,
		BFX_OP_BRANCH_HALF_CARRY_ZERO = 6'h10,
		BFX_OP_BRANCH_T_ONE          = 6'h11,
		BFX_OP_BRANCH_T_ZERO         = 6'h12,
		BFX_OP_BRANCH_OVERFLOW_ONE   = 6'h13,
		BFX_OP_BRANCH_OVERFLOW_ZERO  = 6'h14,
		BFX_OP_BRANCH_IRQ_ENABLED    = 6'h15,
		BFX_OP_BRANCH_IRQ_DISABLED   = 6'h16,
		BFX_OP_IO_BIT_FORCE_ONE      = 6'h17,
		BFX_OP_IO_BIT_FORCE_ZERO     = 6'h18,
		BFX_OP_LOGICAL_RIGHT_SHIFT   = 6'h19,
		BFX_OP_ROTATE_LEFT_CARRY     = 6'h1a,
		BFX_OP_ROTATE_RIGHT_CARRY    = 6'h1b,
		BFX_OP_ARITH_RIGHT_SHIFT     = 6'h1c,
		BFX_OP_NIBBLE_SWAP           = 6'h1d,
		BFX_OP_GENERIC_FLAG_ONE      = 6'h1e,
		BFX_OP_GENERIC_FLAG_ZERO     = 6'h1f,
		BFX_OP_COPY_BIT_TO_T         = 6'h20,
		BFX_OP_COPY_T_TO_BIT         = 6'h21,
		BFX_OP_GLOBAL_IRQ_ON         = 6'h22,
		BFX_OP_GLOBAL_IRQ_OFF        = 6'h23,
		BFX_OP_SIGN_FLAG_ON          = 6'h24,
		BFX_OP_SIGN_FLAG_OFF         = 6'h25,
		BFX_OP_OVERFLOW_FLAG_ON      = 6'h26,
		BFX_OP_OVERFLOW_FLAG_OFF     = 6'h27,
		BFX_OP_HALF_CARRY_ON         = 6'h28,
		BFX_OP_HALF_CARRY_OFF        = 6'h29,
		BFX_OP_ZERO_FLAG_ON          = 6'h2a,
		BFX_OP_ZERO_FLAG_OFF         = 6'h2b,
		BFX_OP_NEGATIVE_FLAG_ON      = 6'h2c,
		BFX_OP_NEGATIVE_FLAG_OFF     = 6'h2d,
		BFX_OP_CARRY_FLAG_ON         = 6'h2e,
		BFX_OP_CARRY_FLAG_OFF        = 6'h2f,
		BFX_OP_T_FLAG_ON             = 6'h30,
		BFX_OP_T_FLAG_OFF            = 6'h31
	} bfx_op_t;

	typedef enum logic [1:0] {
		BFX_ST_IDLE = 2'b01,
		BFX_ST_WAIT = 2'b10
	} bfx_state_t;

	typedef struct packed {
		bfx_op_t    op;
		logic [2:0] reg_idx;
		logic [2:0] bit_sel;
		logic [2:0] flag_sel;
		logic [2:0] io_addr;
		logic [6:0] offset;
		logic       next_two_word;
	} bfx_instr_t;

	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bfx_bus_t;

	typedef struct packed {
		logic       is_br;
		logic       is_signed;
		logic       use_sel;
		logic [2:0] idx;
		logic       pol;
		logic       is_flag;
	} bfx_dec_t;

endpackage

// ==== verilog/bfx_exec.sv ====
// branch, skip, bit, shift and flag execution unit with register port
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module bfx_exec import bfx_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        instr_valid,
	input  wire bfx_instr_t  instr,
	output logic             instr_ready,
	output logic             instr_done,
	output logic [15:0]      pc,
	output logic [7:0]       status_flags,
	input  wire bfx_bus_t    bus,
	output logic [7:0]       bus_rdata
);

	function automatic bfx_dec_t mk_br(logic [2:0] idx, logic pol);
		bfx_dec_t d;
		d = '0;
		d.is_br = 1'b1;
		d.idx = idx;
		d.pol = pol;
		return d;
	endfunction

	function automatic bfx_dec_t mk_flag(logic [2:0] idx, logic val);
		bfx_dec_t d;
		d = '0;
		d.is_flag = 1'b1;
		d.idx = idx;
		d.pol = val;
		return d;
	endfunction

	function automatic bfx_dec_t bfx_decode(bfx_op_t op);
		bfx_dec_t d;
		d = '0;
		case (op)
			BFX_OP_BRANCH_FLAG_S_SET: begin
				d = mk_br(BFX_FLAG_C, 1'b1);
				d.use_sel = 1'b1;
			end
			BFX_OP_BRANCH_FLAG_S_CLEAR: begin
				d = mk_br(BFX_FLAG_C, 1'b0);
				d.use_sel = 1'b1;
			end
			BFX_OP_BRANCH_EQUAL:           d = mk_br(BFX_FLAG_Z, 1'b1);
			BFX_OP_BRANCH_NOT_EQUAL:       d = mk_br(BFX_FLAG_Z, 1'b0);
			BFX_OP_BRANCH_CARRY_ONE:       d = mk_br(BFX_FLAG_C, 1'b1);
			BFX_OP_BRANCH_CARRY_ZERO:      d = mk_br(BFX_FLAG_C, 1'b0);
			BFX_OP_BRANCH_UNSIGNED_GE:     d = mk_br(BFX_FLAG_C, 1'b0);
			BFX_OP_BRANCH_UNSIGNED_LT:     d = mk_br(BFX_FLAG_C, 1'b1);
			BFX_OP_BRANCH_NEGATIVE:        d = mk_br(BFX_FLAG_N, 1'b1);
			BFX_OP_BRANCH_POSITIVE:        d = mk_br(BFX_FLAG_N, 1'b0);
			BFX_OP_BRANCH_SIGNED_GE: begin
				d = mk_br(BFX_FLAG_N, 1'b0);
				d.is_signed = 1'b1;
			end
			BFX_OP_BRANCH_SIGNED_LT: begin
				d = mk_br(BFX_FLAG_N, 1'b1);
				d.is_signed = 1'b1;
			end
			BFX_OP_BRANCH_HALF_CARRY_ONE:  d = mk_br(BFX_FLAG_H, 1'b1);
			BFX_OP_BRANCH_HALF_CARRY_ZERO: d = mk_br(BFX_FLAG_H, 1'b0);
			BFX_OP_BRANCH_T_ONE:           d = mk_br(BFX_FLAG_T, 1'b1);
			BFX_OP_BRANCH_T_ZERO:          d = mk_br(BFX_FLAG_T, 1'b0);
			BFX_OP_BRANCH_OVERFLOW_ONE:    d = mk_br(BFX_FLAG_V, 1'b1);
			BFX_OP_BRANCH_OVERFLOW_ZERO:   d = mk_br(BFX_FLAG_V, 1'b0);
			BFX_OP_BRANCH_IRQ_ENABLED:     d = mk_br(BFX_FLAG_I, 1'b1);
			BFX_OP_BRANCH_IRQ_DISABLED:    d = mk_br(BFX_FLAG_I, 1'b0);
			BFX_OP_GENERIC_FLAG_ONE: begin
				d = mk_flag(BFX_FLAG_C, 1'b1);
				d.use_sel = 1'b1;
			end
			BFX_OP_GENERIC_FLAG_ZERO: begin
				d = mk_flag(BFX_FLAG_C, 1'b0);
				d.use_sel = 1'b1;
			end
			BFX_OP_GLOBAL_IRQ_ON:          d = mk_flag(BFX_FLAG_I, 1'b1);
			BFX_OP_GLOBAL_IRQ_OFF:         d = mk_flag(BFX_FLAG_I, 1'b0);
			BFX_OP_SIGN_FLAG_ON:           d = mk_flag(BFX_FLAG_S, 1'b1);
			BFX_OP_SIGN_FLAG_OFF:          d = mk_flag(BFX_FLAG_S, 1'b0);
			BFX_OP_OVERFLOW_FLAG_ON:       d = mk_flag(BFX_FLAG_V, 1'b1);
			BFX_OP_OVERFLOW_FLAG_OFF:      d = mk_flag(BFX_FLAG_V, 1'b0);
			BFX_OP_HALF_CARRY_ON:          d = mk_flag(BFX_FLAG_H, 1'b1);
			BFX_OP_HALF_CARRY_OFF:         d = mk_flag(BFX_FLAG_H, 1'b0);
			BFX_OP_ZERO_FLAG_ON:           d = mk_flag(BFX_FLAG_Z, 1'b1);
			BFX_OP_ZERO_FLAG_OFF:          d = mk_flag(BFX_FLAG_Z, 1'b0);
			BFX_OP_NEGATIVE_FLAG_ON:       d = mk_flag(BFX_FLAG_N, 1'b1);
			BFX_OP_NEGATIVE_FLAG_OFF:      d = mk_flag(BFX_FLAG_N, 1'b0);
			BFX_OP_CARRY_FLAG_ON:          d = mk_flag(BFX_FLAG_C, 1'b1);
			BFX_OP_CARRY_FLAG_OFF:         d = mk_flag(BFX_FLAG_C, 1'b0);
			BFX_OP_T_FLAG_ON:              d = mk_flag(BFX_FLAG_T, 1'b1);
			BFX_OP_T_FLAG_OFF:             d = mk_flag(BFX_FLAG_T, 1'b0);
			default: d = '0;
		endcase
		return d;
	endfunction

	logic [7:0]  gpr [8];
	logic [7:0]  io_mem [8];
	bfx_state_t  state;
	logic [1:0]  wait_cnt;

	// instruction side decode
	wire         acc = instr_valid && instr_ready;
	bfx_dec_t    dec;
	assign dec = bfx_decode(instr.op);
	wire [2:0]   flag_idx = dec.use_sel ? instr.flag_sel : dec.idx;
	wire [7:0]   src      = gpr[instr.reg_idx];
	wire [7:0]   io_val   = io_mem[instr.io_addr];
	wire         io_bit   = io_val[instr.bit_sel];
	wire         br_cond  = dec.is_signed ? (status_flags[BFX_FLAG_N] ^ status_flags[BFX_FLAG_V])
	                                      : status_flags[flag_idx];
	wire         br_taken = dec.is_br && (br_cond == dec.pol);
	wire [15:0]  br_target = pc + BFX_PC_STEP + {{9{instr.offset[6]}}, instr.offset};
	wire         is_skip_op = (instr.op == BFX_OP_SKIP_IF_IO_BIT_ONE)
	                       || (instr.op == BFX_OP_SKIP_IF_IO_BIT_ZERO);
	wire         skip_cond = ((instr.op == BFX_OP_SKIP_IF_IO_BIT_ONE) && io_bit)
	                      || ((instr.op == BFX_OP_SKIP_IF_IO_BIT_ZERO) && !io_bit);
	wire         io_we = (instr.op == BFX_OP_IO_BIT_FORCE_ONE)
	                  || (instr.op == BFX_OP_IO_BIT_FORCE_ZERO);
	wire         is_shift = (instr.op == BFX_OP_LOGICAL_RIGHT_SHIFT)
	                     || (instr.op == BFX_OP_ROTATE_LEFT_CARRY)
	                     || (instr.op == BFX_OP_ROTATE_RIGHT_CARRY)
	                     || (instr.op == BFX_OP_ARITH_RIGHT_SHIFT);

	// skip distance by next word count
	wire [15:0]  skip_step = instr.next_two_word ? BFX_PC_SKIP_TWO : BFX_PC_SKIP_ONE;
	wire [15:0]  next_pc = br_taken ? br_target
	                     : skip_cond ? pc + skip_step
	                     : pc + BFX_PC_STEP;

	wire [1:0]   cycles = br_taken ? BFX_CYC_TWO
	                    : skip_cond ? (instr.next_two_word ? BFX_CYC_THREE : BFX_CYC_TWO)
	                    : io_we ? BFX_CYC_TWO
	                    : BFX_CYC_ONE;

	logic [7:0]  io_wd;
	always_comb begin
		io_wd = io_val;
		io_wd[instr.bit_sel] = (instr.op == BFX_OP_IO_BIT_FORCE_ONE);
	end

	logic [7:0]  alu_res;
	logic        c_out;
	logic        gpr_we;
	logic [7:0]  next_status_flags_register;
	always_comb begin
		alu_res = src;
		c_out = status_flags[BFX_FLAG_C];
		gpr_we = 1'b0;
		next_status_flags_register = status_flags;
		case (instr.op)
			BFX_OP_LOGICAL_RIGHT_SHIFT: begin
				alu_res = {1'b0, src[7:1]};
				c_out = src[0];
				gpr_we = 1'b1;
			end
			BFX_OP_ROTATE_LEFT_CARRY: begin
				{c_out, alu_res} = {src, status_flags[BFX_FLAG_C]};
				gpr_we = 1'b1;
			end
			BFX_OP_ROTATE_RIGHT_CARRY: begin
				{alu_res, c_out} = {status_flags[BFX_FLAG_C], src};
				gpr_we = 1'b1;
			end
			BFX_OP_ARITH_RIGHT_SHIFT: begin
				alu_res = {src[7], src[7:1]};
				c_out = src[0];
				gpr_we = 1'b1;
			end
			BFX_OP_NIBBLE_SWAP: begin
				alu_res = {src[3:0], src[7:4]};
				gpr_we = 1'b1;
			end
			BFX_OP_COPY_T_TO_BIT: begin
				alu_res[instr.bit_sel] = status_flags[BFX_FLAG_T];
				gpr_we = 1'b1;
			end
			BFX_OP_COPY_BIT_TO_T: begin
				next_status_flags_register[BFX_FLAG_T] = src[instr.bit_sel];
			end
			default: begin
				gpr_we = 1'b0;
			end
		endcase
		if (is_shift) begin
			next_status_flags_register[BFX_FLAG_Z] = (alu_res == BFX_BYTE_RST);
			next_status_flags_register[BFX_FLAG_C] = c_out;
			next_status_flags_register[BFX_FLAG_N] = alu_res[7];
			next_status_flags_register[BFX_FLAG_V] = alu_res[7] ^ c_out;
		end
		if (dec.is_flag) begin
			next_status_flags_register[flag_idx] = dec.pol;
		end
	end

	wire         status_flags_register_we = acc && (is_shift || dec.is_flag
	                       || (instr.op == BFX_OP_COPY_BIT_TO_T));

	// register bus decode
	wire         bus_gpr = (bus.addr[4:3] == BFX_REGION_GPR);
	wire         bus_io  = (bus.addr[4:3] == BFX_REGION_IO);
	wire         bus_wr_status = bus.wr && (bus.addr == BFX_ADDR_STATUS);
	wire         bus_wr_pc_lo  = bus.wr && (bus.addr == BFX_ADDR_PC_LO);
	wire         bus_wr_pc_hi  = bus.wr && (bus.addr == BFX_ADDR_PC_HI);
	logic [7:0]  next_rdata;
	always_comb begin
		if (!bus.rd) begin
			next_rdata = BFX_BYTE_RST;
		end else if (bus.addr == BFX_ADDR_STATUS) begin
			next_rdata = status_flags;
		end else if (bus.addr == BFX_ADDR_PC_LO) begin
			next_rdata = pc[7:0];
		end else if (bus.addr == BFX_ADDR_PC_HI) begin
			next_rdata = pc[15:8];
		end else if (bus_gpr) begin
			next_rdata = gpr[bus.addr[2:0]];
		end else if (bus_io) begin
			next_rdata = io_mem[bus.addr[2:0]];
		end else begin
			next_rdata = BFX_BYTE_RST;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			bus_rdata <= BFX_BYTE_RST;
		end else begin
			bus_rdata <= next_rdata;
		end
	end

	// instruction write wins over a bus write to the same target
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			status_flags <= BFX_STATUS_FLAGS_REGISTER_RST;
		end else if (status_flags_register_we) begin
			status_flags <= next_status_flags_register;
		end else if (bus_wr_status) begin
			status_flags <= bus.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			pc <= BFX_PC_RST;
		end else if (acc) begin
			pc <= next_pc;
		end else if (bus_wr_pc_lo) begin
			pc[7:0] <= bus.wdata;
		end else if (bus_wr_pc_hi) begin
			pc[15:8] <= bus.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		for (int i = 0; i < 8; i++) begin
			if (!rstn) begin
				gpr[i] <= BFX_BYTE_RST;
				io_mem[i] <= BFX_BYTE_RST;
			end else begin
				if (acc && gpr_we && (instr.reg_idx == 3'(i))) begin
					gpr[i] <= alu_res;
				end else if (bus.wr && bus_gpr && (bus.addr[2:0] == 3'(i))) begin
					gpr[i] <= bus.wdata;
				end
				if (acc && io_we && (instr.io_addr == 3'(i))) begin
					io_mem[i] <= io_wd;
				end else if (bus.wr && bus_io && (bus.addr[2:0] == 3'(i))) begin
					io_mem[i] <= bus.wdata;
				end
			end
		end
	end

	// cycle sequencer
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state <= BFX_ST_IDLE;
			wait_cnt <= 2'h0;
			instr_ready <= 1'b1;
			instr_done <= 1'b0;
		end else begin
			instr_done <= 1'b0;
			case (state)
				BFX_ST_IDLE: begin
					if (acc && (cycles == BFX_CYC_ONE)) begin
						instr_done <= 1'b1;
					end else if (acc) begin
						state <= BFX_ST_WAIT;
						instr_ready <= 1'b0;
						wait_cnt <= cycles - BFX_CYC_TWO;
					end
				end
				BFX_ST_WAIT: begin
					if (wait_cnt == 2'h0) begin
						state <= BFX_ST_IDLE;
						instr_ready <= 1'b1;
						instr_done <= 1'b1;
					end else begin
						wait_cnt <= wait_cnt - 2'h1;
					end
				end
				default: begin
					state <= BFX_ST_IDLE;
					instr_ready <= 1'b1;
				end
			endcase
		end
	end

	property p_skip_one;
		@(posedge mclk) disable iff (!rstn)
		acc && instr.op == BFX_OP_SKIP_IF_IO_BIT_ONE && io_bit && !instr.next_two_word
		|=> pc == $past(pc) + BFX_PC_SKIP_ONE ##1 instr_done && instr_ready;
	endproperty
	a_skip_one: assert property (p_skip_one) else $error("skip on one wrong");

	property p_skip_zero;
		@(posedge mclk) disable iff (!rstn)
		acc && instr.op == BFX_OP_SKIP_IF_IO_BIT_ZERO && io_bit
		|=> pc == $past(pc) + BFX_PC_STEP && instr_done;
	endproperty
	a_skip_zero: assert property (p_skip_zero) else $error("skip on zero wrong");

	property p_skip_three;
		@(posedge mclk) disable iff (!rstn)
		acc && is_skip_op && skip_cond && instr.next_two_word
		|=> !instr_ready [*2] ##1 instr_ready && instr_done;
	endproperty
	a_skip_three: assert property (p_skip_three) else $error("skip timing wrong");

	property p_branch_taken;
		@(posedge mclk) disable iff (!rstn)
		acc && br_taken |=> pc == $past(br_target) && !instr_ready ##1 instr_done;
	endproperty
	a_branch_taken: assert property (p_branch_taken) else $error("taken branch wrong");

	property p_branch_equal;
		@(posedge mclk) disable iff (!rstn)
		acc && instr.op == BFX_OP_BRANCH_EQUAL && !status_flags[BFX_FLAG_Z]
		|=> pc == $past(pc) + BFX_PC_STEP && instr_done;
	endproperty
	a_branch_equal: assert property (p_branch_equal) else $error("equal branch wrong");

	property p_branch_signed;
		@(posedge mclk) disable iff (!rstn)
		acc && instr.op == BFX_OP_BRANCH_SIGNED_LT
		&& (status_flags[BFX_FLAG_N] != status_flags[BFX_FLAG_V])
		|=> pc == $past(br_target);
	endproperty
	a_branch_signed: assert property (p_branch_signed) else $error("signed branch wrong");

	property p_branch_keeps_flags;
		@(posedge mclk) disable iff (!rstn)
		acc && dec.is_br && !bus.wr |=> $stable(status_flags);
	endproperty
	a_branch_keeps_flags: assert property (p_branch_keeps_flags) else $error("flags moved");

	property p_io_force;
		@(posedge mclk) disable iff (!rstn)
		acc && instr.op == BFX_OP_IO_BIT_FORCE_ONE
		|=> io_mem[$past(instr.io_addr)][$past(instr.bit_sel)] && !instr_ready ##1 instr_done;
	endproperty
	a_io_force: assert property (p_io_force) else $error("io force wrong");

	property p_lsr;
		@(posedge mclk) disable iff (!rstn)
		acc && instr.op == BFX_OP_LOGICAL_RIGHT_SHIFT
		|=> gpr[$past(instr.reg_idx)] == ($past(src) >> 1)
		&& status_flags[BFX_FLAG_C] == $past(src[0]) && !status_flags[BFX_FLAG_N];
	endproperty
	a_lsr: assert property (p_lsr) else $error("logical shift wrong");

	property p_rol;
		@(posedge mclk) disable iff (!rstn)
		acc && instr.op == BFX_OP_ROTATE_LEFT_CARRY
		|=> gpr[$past(instr.reg_idx)][0] == $past(status_flags[BFX_FLAG_C])
		&& status_flags[BFX_FLAG_C] == $past(src[7]);
	endproperty
	a_rol: assert property (p_rol) else $error("rotate left wrong");

	property p_swap;
		@(posedge mclk) disable iff (!rstn)
		acc && instr.op == BFX_OP_NIBBLE_SWAP && !bus.wr
		|=> gpr[$past(instr.reg_idx)] == {$past(src[3:0]), $past(src[7:4])}
		&& $stable(status_flags);
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");

	property p_irq_on;
		@(posedge mclk) disable iff (!rstn)
		acc && instr.op == BFX_OP_GLOBAL_IRQ_ON
		|=> status_flags == ($past(status_flags) | 8'h80);
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq enable wrong");

endmodule

// ==== dv/bfx_exec_tb_top.sv ====
// self-checking bench of the branch, bit and flag execution unit
`timescale 1ns/1ns
module bfx_exec_tb_top;
	import bfx_pkg::*;

	// flag index per branch pair from op 0x05, and per dedicated set/clear pair
	localparam logic [26:0] BIDX = {3'h7, 3'h3, 3'h6, 3'h5, 3'h0, 3'h2, 3'h0, 3'h0, 3'h1};
	localparam logic [23:0] FIDX = {3'h6, 3'h0, 3'h2, 3'h1, 3'h5, 3'h3, 3'h4, 3'h7};

	logic        mclk;
	logic        rstn;
	logic        instr_valid;
	bfx_instr_t  instr;
	logic        instr_ready;
	logic        instr_done;
	logic [15:0] pc;
	logic [7:0]  status_flags;
	bfx_bus_t    bus;
	logic [7:0]  bus_rdata;
	int          err_count;
	int          n_compared;
	int          cyc = 0;
	logic [31:0] seed;
	logic [31:0] r;
	logic [15:0] m_pc;
	logic [7:0]  m_sr;
	logic [7:0]  m_gpr [8];
	logic [7:0]  m_io [8];
	int          m_n;

	bfx_exec i_dut (
		.mclk         (mclk),
		.rstn         (rstn),
		.instr_valid  (instr_valid),
		.instr        (instr),
		.instr_ready  (instr_ready),
		.instr_done   (instr_done),
		.pc           (pc),
		.status_flags (status_flags),
		.bus          (bus),
		.bus_rdata    (bus_rdata)
	);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end

	// one bus cycle; on a read d is the expected data
	task automatic bio(input logic wr, input logic [4:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: wr, rd: !wr};
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
		#1;
		if (!wr) chk({8'h0, bus_rdata}, {8'h0, d});
	endtask

	task automatic model(input bfx_instr_t v);
		logic [7:0] x;
		logic [7:0] q;
		logic       f;
		int         p;
		x = m_gpr[v.reg_idx];
		q = x;
		p = (int'(v.op) - 5) / 2;
		m_n = 1;
		f = v.op < 6'h05 ? m_sr[v.flag_sel] :
			(p == 4 ? m_sr[2] ^ m_sr[3] : m_sr[BIDX[p*3 +: 3]]);
		// unsigned and signed pairs: odd code is the cleared form
		f = f ~^ (v.op[0] ^ ((p == 2 || p == 4) && v.op >= 6'h05));
		if (v.op >= 6'h03 && v.op <= 6'h16) begin
			m_n = f ? 2 : 1;
			m_pc = m_pc + (f ? {{9{v.offset[6]}}, v.offset} : 16'h0);
		end
		if (v.op == 6'h01 || v.op == 6'h02) begin
			f = m_io[v.io_addr][v.bit_sel] ^ v.op[1];
			m_n = f ? 2 + v.next_two_word : 1;
			m_pc = m_pc + (f ? 16'h1 + v.next_two_word : 16'h0);
		end
		m_pc = m_pc + 16'h1;
		case (v.op)
			BFX_OP_IO_BIT_FORCE_ONE, BFX_OP_IO_BIT_FORCE_ZERO: begin
				m_io[v.io_addr][v.bit_sel] = v.op[0];
				m_n = 2;
			end
			BFX_OP_LOGICAL_RIGHT_SHIFT: q = {1'b0, x[7:1]};
			BFX_OP_ROTATE_LEFT_CARRY:   q = {x[6:0], m_sr[0]};
			BFX_OP_ROTATE_RIGHT_CARRY:  q = {m_sr[0], x[7:1]};
			BFX_OP_ARITH_RIGHT_SHIFT:   q = {x[7], x[7:1]};
			BFX_OP_NIBBLE_SWAP:         q = {x[3:0], x[7:4]};
			BFX_OP_GENERIC_FLAG_ONE:    m_sr[v.flag_sel] = 1'b1;
			BFX_OP_GENERIC_FLAG_ZERO:   m_sr[v.flag_sel] = 1'b0;
			BFX_OP_COPY_BIT_TO_T:       m_sr[6] = x[v.bit_sel];
			BFX_OP_COPY_T_TO_BIT:       q[v.bit_sel] = m_sr[6];
			default: begin
				if (v.op >= 6'h22) m_sr[FIDX[(v.op - 6'h22) / 2 * 3 +: 3]] = !v.op[0];
			end
		endcase
		if (v.op >= 6'h19 && v.op <= 6'h1c) begin
			f = v.op == 6'h1a ? x[7] : x[0];
			m_sr[3:0] = {q[7] ^ f, q[7], q == 8'h0, f};
		end
		m_gpr[v.reg_idx] = q;
	endtask

	task automatic exec(input logic [5:0] o);
		bfx_instr_t v;
		int         cnt;
		r = rnd();
		v = '{op: bfx_op_t'(o), reg_idx: r[2:0], bit_sel: r[5:3], flag_sel: r[8:6],
			io_addr: r[11:9], offset: r[18:12], next_two_word: r[19]};
		instr <= v;
		instr_valid <= 1'b1;
		@(posedge mclk);
		instr_valid <= 1'b0;
		model(v);
		#1;
		chk({15'h0, instr_ready}, {15'h0, m_n == 1});
		cnt = 1;
		while (instr_done !== 1'b1 && cnt < 8) begin
			@(posedge mclk);
			#1;
			cnt++;
		end
		chk(16'(cnt), 16'(m_n));
		chk(pc, m_pc);
		chk({8'h0, status_flags}, {8'h0, m_sr});
	endtask

	task automatic do_reset();
		rstn <= 1'b0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		#1;
		chk(pc, BFX_PC_RST);
		chk({8'h0, status_flags}, {8'h0, BFX_STATUS_FLAGS_REGISTER_RST});
		m_pc = BFX_PC_RST;
		m_sr = BFX_STATUS_FLAGS_REGISTER_RST;
		bio(1'b0, 5'h08, 8'h00);
	endtask

	initial begin
		rstn = 1'b0;
		instr_valid = 1'b0;
		instr = '0;
		bus = '0;
		seed = 32'hfd97;
		err_count = 0;
		n_compared = 0;
		do_reset();
		for (int b = 0; b < 3; b++) begin
			for (int i = 0; i < 8; i++) begin
				r = rnd();
				m_gpr[i] = r[7:0];
				m_io[i] = r[15:8];
				bio(1'b1, 5'h08 + i[4:0], m_gpr[i]);
				bio(1'b1, 5'h10 + i[4:0], m_io[i]);
			end
			r = rnd();
			m_sr = r[7:0];
			m_pc = r[23:8];
			bio(1'b1, BFX_ADDR_STATUS, m_sr);
			bio(1'b1, BFX_ADDR_PC_LO, m_pc[7:0]);
			bio(1'b1, BFX_ADDR_PC_HI, m_pc[15:8]);
			for (int o = 0; o < 50; o++) exec(o[5:0]);
			repeat (150) begin
				r = rnd();
				exec(6'(r[7:0] % 50));
			end
			for (int i = 0; i < 8; i++) begin
				bio(1'b0, 5'h08 + i[4:0], m_gpr[i]);
				bio(1'b0, 5'h10 + i[4:0], m_io[i]);
			end
			bio(1'b0, BFX_ADDR_STATUS, m_sr);
			bio(1'b0, BFX_ADDR_PC_HI, m_pc[15:8]);
			bio(1'b1, 5'h05, 8'ha5);
			bio(1'b0, 5'h05, 8'h00);
			bio(1'b0, 5'h1f, 8'h00);
		end
		do_reset();
		test_done();
	end
endmodule
